// [cod_pkg.sv]
// Constants of the clock output divider and its register map
// Function
// RQ1 - Two-bit source field picks internal, low-speed, high-speed or system clock.
// RQ2 - Internal and high-speed sources divide by 1 up to 128, powers of two.
// RQ3 - Low-speed divides 1,2,4,8,256,1024,4096,32768; system clock only 1/1.
// RQ4 - System clock source gives no output while standby stops that clock.
// RQ5 - Enable bit drives the divided clock to the pin; clear blocks it.
// RQ6 - Enable acts unsynchronised to the divided clock; short pulses possible.
// RQ7 - Three enable bits pass or mask each oscillator's stable interrupt.
// RQ8 - Stable flags set at wait end, read 1 pending, cleared by writing 1.
// RQ9 - Disabled output stays low; divider restarts from reset when re-enabled.
package cod_pkg;

    // Register byte offsets
    localparam logic [11:0] OFS_CLOCK_OUTPUT_CONTROL = 12'h000;
    localparam logic [11:0] OFS_CLOCKGEN_INTERRUPT_FLAG = 12'h004;
    localparam logic [11:0] OFS_CLOCKGEN_INTERRUPT_ENABLE = 12'h008;

    // Control register fields
    localparam int POS_OUTPUT_PIN_ENABLE = 0;
    localparam int POS_SOURCE_LO = 2;
    localparam int POS_DIVISION_LO = 4;
    localparam logic [6:0] CONTROL_WRITE_MASK = 7'h7D;
    localparam logic [6:0] CONTROL_RESET = 7'h00;

    // Interrupt flag and enable fields
    localparam int POS_INTERNAL_STABLE = 0;
    localparam int POS_LOW_SPEED_STABLE = 1;
    localparam int POS_HIGH_SPEED_STABLE = 2;
    localparam logic [2:0] FLAG_RESET = 3'h0;
    localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;

    // Source select codes
    localparam logic [1:0] SRC_INTERNAL = 2'h0;
    localparam logic [1:0] SRC_LOW_SPEED = 2'h1;
    localparam logic [1:0] SRC_HIGH_SPEED = 2'h2;
    localparam logic [1:0] SRC_SYSTEM = 2'h3;

    // Low-speed upper division codes as log2 of divisor
    localparam logic [3:0] LS_SHIFT_CODE4 = 4'h8;
    localparam logic [3:0] LS_SHIFT_CODE5 = 4'hA;
    localparam logic [3:0] LS_SHIFT_CODE6 = 4'hC;
    localparam logic [3:0] LS_SHIFT_CODE7 = 4'hF;

    // Divider counter width, enough for 1/32768
    localparam int DIV_COUNT_WIDTH = 15;

    // Bus phases of the register slave
    typedef enum logic [1:0] {
        COD_IDLE,
        COD_ACCESS
    } cod_bus_type;

endpackage : cod_pkg

// [cod_divider.sv]
// Power-of-two divider stepped by source clock rising edges
`timescale 1ns/1ns
module cod_divider #(
    parameter int WIDTH = cod_pkg::DIV_COUNT_WIDTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Source clock as stable level and rising edge
    input wire logic src_level,
    input wire logic src_rise,
    // Control
    input wire logic clear,
    input wire logic [3:0] shift,
    // Divided level
    output logic div_level
);

    logic [WIDTH-1:0] count;

    ////////////////////////////////////////////////////////////////////////
    // Edge counter, restarted by clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else if (clear) begin
            count <= '0; // [RQ9]
        end else if (src_rise) begin
            count <= count + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit shift-1 toggles every 2^(shift-1) edges: period of 2^shift edges
    always_comb begin
        if (shift == 4'h0) begin
            div_level = src_level;
        end else begin
            div_level = count[shift - 4'h1];
        end
    end

endmodule : cod_divider

// [cod_clock_output_divider.sv]
// Clock output divider with stable interrupts and APB register slave
`timescale 1ns/1ns
module cod_clock_output_divider (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Source clocks from other domains
    input wire logic INTERNAL_OSC_CLOCK,
    input wire logic LOW_SPEED_OSC_CLOCK,
    input wire logic HIGH_SPEED_OSC_CLOCK,
    input wire logic SYSTEM_CLOCK,
    // Standby state, high in sleep or halt
    input wire logic STANDBY_ACTIVE,
    // Stabilization wait end pulses, same clock
    input wire logic INTERNAL_STABLE_DONE,
    input wire logic LOW_SPEED_STABLE_DONE,
    input wire logic HIGH_SPEED_STABLE_DONE,
    // Outputs
    output logic DIVIDED_CLOCK_OUTPUT,
    output logic CLOCKGEN_IRQ
);

    logic [6:0] clock_output_control;
    logic [2:0] clockgen_interrupt_flag;
    logic [2:0] clockgen_interrupt_enable;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] src_stable;
    logic [3:0] src_rise;
    logic [3:0] sys_gate;
    logic standby_s1;
    logic standby_s2;
    logic standby_s3;
    logic standby;
    logic output_pin_enable;
    logic [1:0] output_source_select;
    logic [2:0] output_division_ratio;
    logic [3:0] shift;
    logic sel_level;
    logic sel_rise;
    logic div_level;
    logic div_clear;
    logic [2:0] stable_done;
    logic wr_en;
    logic wr_control;
    logic wr_flag;
    logic wr_enable;
    logic addr_ok;
    logic setup_seen;
    logic [31:0] next_rdata;
    cod_pkg::cod_bus_type bus_state;

    assign output_pin_enable = clock_output_control[cod_pkg::POS_OUTPUT_PIN_ENABLE];
    assign output_source_select = clock_output_control[cod_pkg::POS_SOURCE_LO +: 2];
    assign output_division_ratio = clock_output_control[cod_pkg::POS_DIVISION_LO +: 3];

    ////////////////////////////////////////////////////////////////////////
    // Three-stage synchronisers; level accepted once stages two and three agree
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            sync3 <= 4'h0;
        end else begin
            sync1 <= {SYSTEM_CLOCK, HIGH_SPEED_OSC_CLOCK,
                      LOW_SPEED_OSC_CLOCK, INTERNAL_OSC_CLOCK};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_src
            always_ff @(posedge CORE_CLK or posedge RESET) begin
                if (RESET) begin
                    src_stable[gi] <= 1'b0;
                end else if (sync2[gi] == sync3[gi]) begin
                    src_stable[gi] <= sync3[gi];
                end
            end
            assign src_rise[gi] = (sync2[gi] == sync3[gi]) & sync3[gi] & ~src_stable[gi];
        end
    endgenerate

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            standby_s1 <= 1'b0;
            standby_s2 <= 1'b0;
            standby_s3 <= 1'b0;
            standby <= 1'b0;
        end else begin
            standby_s1 <= STANDBY_ACTIVE;
            standby_s2 <= standby_s1;
            standby_s3 <= standby_s2;
            if (standby_s2 == standby_s3) begin
                standby <= standby_s3;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source selection; system clock frozen in standby
    assign sys_gate = {~standby, 3'h7}; // [RQ4]

    always_comb begin
        case (output_source_select) // [RQ1]
            cod_pkg::SRC_INTERNAL: begin
                sel_level = src_stable[0];
                sel_rise = src_rise[0];
            end
            cod_pkg::SRC_LOW_SPEED: begin
                sel_level = src_stable[1];
                sel_rise = src_rise[1];
            end
            cod_pkg::SRC_HIGH_SPEED: begin
                sel_level = src_stable[2];
                sel_rise = src_rise[2];
            end
            default: begin
                sel_level = src_stable[3] & sys_gate[3]; // [RQ4]
                sel_rise = src_rise[3] & sys_gate[3];
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Division ratio as log2 of the divisor
    always_comb begin
        case (output_source_select)
            cod_pkg::SRC_LOW_SPEED: begin
                case (output_division_ratio) // [RQ3]
                    3'h4: shift = cod_pkg::LS_SHIFT_CODE4;
                    3'h5: shift = cod_pkg::LS_SHIFT_CODE5;
                    3'h6: shift = cod_pkg::LS_SHIFT_CODE6;
                    3'h7: shift = cod_pkg::LS_SHIFT_CODE7;
                    default: shift = {1'b0, output_division_ratio};
                endcase
            end
            cod_pkg::SRC_SYSTEM: begin
                shift = 4'h0; // [RQ3]
            end
            default: begin
                shift = {1'b0, output_division_ratio}; // [RQ2]
            end
        endcase
    end

    // Counter held while disabled or while control is rewritten
    assign div_clear = ~output_pin_enable | wr_control; // [RQ9]

    cod_divider #(
        .WIDTH(cod_pkg::DIV_COUNT_WIDTH)
    ) u_divider (
        .clk(CORE_CLK),
        .rst(RESET),
        .src_level(sel_level),
        .src_rise(sel_rise),
        .clear(div_clear),
        .shift(shift),
        .div_level(div_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin: gated with no alignment to the divided clock
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            DIVIDED_CLOCK_OUTPUT <= 1'b0;
        end else begin
            DIVIDED_CLOCK_OUTPUT <= output_pin_enable & div_level; // [RQ5] [RQ6] [RQ9]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: answer in the first access cycle
    assign addr_ok = (PADDR == cod_pkg::OFS_CLOCK_OUTPUT_CONTROL)
                   | (PADDR == cod_pkg::OFS_CLOCKGEN_INTERRUPT_FLAG)
                   | (PADDR == cod_pkg::OFS_CLOCKGEN_INTERRUPT_ENABLE);
    assign setup_seen = (bus_state == cod_pkg::COD_IDLE) & PSEL & ~PENABLE;
    assign wr_en = PSEL & PENABLE & PREADY & PWRITE;
    assign wr_control = wr_en & (PADDR == cod_pkg::OFS_CLOCK_OUTPUT_CONTROL);
    assign wr_flag = wr_en & (PADDR == cod_pkg::OFS_CLOCKGEN_INTERRUPT_FLAG);
    assign wr_enable = wr_en & (PADDR == cod_pkg::OFS_CLOCKGEN_INTERRUPT_ENABLE);

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (PADDR)
            cod_pkg::OFS_CLOCK_OUTPUT_CONTROL: begin
                next_rdata[6:0] = clock_output_control;
            end
            cod_pkg::OFS_CLOCKGEN_INTERRUPT_FLAG: begin
                next_rdata[2:0] = clockgen_interrupt_flag;
            end
            cod_pkg::OFS_CLOCKGEN_INTERRUPT_ENABLE: begin
                next_rdata[2:0] = clockgen_interrupt_enable;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // Bus phase
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            bus_state <= cod_pkg::COD_IDLE;
        end else begin
            case (bus_state)
                cod_pkg::COD_IDLE: begin
                    if (setup_seen) begin
                        bus_state <= cod_pkg::COD_ACCESS;
                    end
                end
                cod_pkg::COD_ACCESS: begin
                    bus_state <= cod_pkg::COD_IDLE;
                end
                default: begin
                    bus_state <= cod_pkg::COD_IDLE;
                end
            endcase
        end
    end

    // Ready for exactly the first access cycle
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= setup_seen;
        end
    end

    // Error answer for unmapped addresses
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            PSLVERR <= 1'b0;
        end else begin
            PSLVERR <= setup_seen & ~addr_ok;
        end
    end

    // Read data stands with ready only, zero otherwise
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            PRDATA <= 32'h0000_0000;
        end else if (setup_seen && !PWRITE) begin
            PRDATA <= next_rdata;
        end else begin
            PRDATA <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            clock_output_control <= cod_pkg::CONTROL_RESET;
        end else if (wr_control) begin
            clock_output_control <= PWDATA[6:0] & cod_pkg::CONTROL_WRITE_MASK;
        end
    end

    // Interrupt enable register
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            clockgen_interrupt_enable <= cod_pkg::IRQ_ENABLE_RESET;
        end else if (wr_enable) begin
            clockgen_interrupt_enable <= PWDATA[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags: set wins over write-one clear
    assign stable_done = {HIGH_SPEED_STABLE_DONE, LOW_SPEED_STABLE_DONE, INTERNAL_STABLE_DONE};

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            clockgen_interrupt_flag <= cod_pkg::FLAG_RESET;
        end else begin
            clockgen_interrupt_flag <= (clockgen_interrupt_flag
                                      & ~(wr_flag ? PWDATA[2:0] : 3'h0))
                                      | stable_done; // [RQ8]
        end
    end

    // Interrupt output
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            CLOCKGEN_IRQ <= 1'b0;
        end else begin
            CLOCKGEN_IRQ <= |(clockgen_interrupt_flag & clockgen_interrupt_enable); // [RQ7]
        end
    end

endmodule : cod_clock_output_divider

// [cod_monitor.sv]
// Checker of bus answers, pin gating and interrupt level
`timescale 1ns/1ns
module cod_monitor (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET,
    // Bus
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Events and outputs
    input wire logic STANDBY_ACTIVE,
    input wire logic INTERNAL_STABLE_DONE,
    input wire logic LOW_SPEED_STABLE_DONE,
    input wire logic HIGH_SPEED_STABLE_DONE,
    input wire logic DIVIDED_CLOCK_OUTPUT,
    input wire logic CLOCKGEN_IRQ
);
    logic [6:0] ctrl;
    logic [2:0] flag;
    logic [2:0] ien;
    logic wr;
    logic mapped;
    logic pend;

    assign wr = PSEL && PENABLE && PREADY && PWRITE;
    assign mapped = PADDR inside {cod_pkg::OFS_CLOCK_OUTPUT_CONTROL,
        cod_pkg::OFS_CLOCKGEN_INTERRUPT_FLAG, cod_pkg::OFS_CLOCKGEN_INTERRUPT_ENABLE};
    assign pend = |(flag & ien);

    // Shadow of the register state
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            ctrl <= 7'h00;
            flag <= 3'h0;
            ien <= 3'h0;
        end else begin
            if (wr && PADDR == cod_pkg::OFS_CLOCK_OUTPUT_CONTROL) begin
                ctrl <= PWDATA[6:0] & cod_pkg::CONTROL_WRITE_MASK;
            end
            if (wr && PADDR == cod_pkg::OFS_CLOCKGEN_INTERRUPT_ENABLE) begin
                ien <= PWDATA[2:0];
            end
            flag <= (flag & ~((wr && PADDR == cod_pkg::OFS_CLOCKGEN_INTERRUPT_FLAG) ?
                PWDATA[2:0] : 3'h0)) | {HIGH_SPEED_STABLE_DONE, LOW_SPEED_STABLE_DONE,
                INTERNAL_STABLE_DONE};
        end
    end

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);

    a_ready_pulse: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
        else $error("ready not a single cycle after setup");
    a_unmapped_err: assert property (PSEL && !PENABLE && !mapped |=> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_okay: assert property (PSEL && !PENABLE && mapped |=> !PSLVERR)
        else $error("mapped access refused");
    a_read_ctrl: assert property (
        PREADY && !PWRITE && PADDR == cod_pkg::OFS_CLOCK_OUTPUT_CONTROL |-> PRDATA[6:0] == ctrl)
        else $error("control read back wrong");
    a_read_flag: assert property (
        PREADY && !PWRITE && PADDR == cod_pkg::OFS_CLOCKGEN_INTERRUPT_FLAG
        |-> PRDATA[2:0] == $past(flag)) else $error("flag read back wrong");
    a_upper_zero: assert property (PREADY && !PWRITE |-> PRDATA[31:7] == 25'h0)
        else $error("reserved bits read nonzero");
    a_pin_off: assert property (!ctrl[0] && !$past(ctrl[0]) |-> !DIVIDED_CLOCK_OUTPUT)
        else $error("pin not low while disabled");
    a_irq_level: assert property (CLOCKGEN_IRQ == $past(pend))
        else $error("interrupt level wrong");
    a_standby_low: assert property (
        (STANDBY_ACTIVE && ctrl[3:2] == cod_pkg::SRC_SYSTEM)[*8] |-> !DIVIDED_CLOCK_OUTPUT)
        else $error("pin active in standby");
endmodule : cod_monitor

bind cod_clock_output_divider cod_monitor i_monitor (
    .CORE_CLK(CORE_CLK),
    .RESET(RESET),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PWDATA(PWDATA),
    .PRDATA(PRDATA),
    .PREADY(PREADY),
    .PSLVERR(PSLVERR),
    .STANDBY_ACTIVE(STANDBY_ACTIVE),
    .INTERNAL_STABLE_DONE(INTERNAL_STABLE_DONE),
    .LOW_SPEED_STABLE_DONE(LOW_SPEED_STABLE_DONE),
    .HIGH_SPEED_STABLE_DONE(HIGH_SPEED_STABLE_DONE),
    .DIVIDED_CLOCK_OUTPUT(DIVIDED_CLOCK_OUTPUT),
    .CLOCKGEN_IRQ(CLOCKGEN_IRQ)
);

// [cod_clock_sink.sv]
// External circuit counting rising edges of the divided clock
`timescale 1ns/1ns
module cod_clock_sink (
    // Clock pin
    input wire logic clk_in,
    // Edge count
    output int rise_count
);
    always @(posedge clk_in) rise_count <= rise_count + 1;
endmodule : cod_clock_sink

// [cod_clock_output_divider_tb.sv]
// Self-checking bench of the clock output divider
`timescale 1ns/1ns
module cod_clock_output_divider_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic src0 = 1'b0;
    logic src1 = 1'b0;
    logic src2 = 1'b0;
    logic src3 = 1'b0;
    logic standby = 1'b0;
    logic [2:0] done = 3'h0;
    logic pin;
    logic irq;
    logic [31:0] rd;
    logic er;
    int rises;
    int c0;
    int per;
    int mismatches = 0;
    int samples_checked = 0;
    localparam int HALF[4] = '{16, 20, 14, 18};

    always #2 clk = ~clk;
    always #16 src0 = ~src0;
    always #20 src1 = ~src1;
    // Offset keeps these toggles off the sampling edge
    initial begin
        #1;
        forever #14 src2 = ~src2;
    end
    initial begin
        #1;
        forever #18 src3 = ~src3;
    end

    cod_clock_output_divider i_dut (.CORE_CLK(clk), .RESET(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .INTERNAL_OSC_CLOCK(src0),
        .LOW_SPEED_OSC_CLOCK(src1), .HIGH_SPEED_OSC_CLOCK(src2), .SYSTEM_CLOCK(src3),
        .STANDBY_ACTIVE(standby), .INTERNAL_STABLE_DONE(done[0]),
        .LOW_SPEED_STABLE_DONE(done[1]), .HIGH_SPEED_STABLE_DONE(done[2]),
        .DIVIDED_CLOCK_OUTPUT(pin), .CLOCKGEN_IRQ(irq));
    cod_clock_sink i_sink (.clk_in(pin), .rise_count(rises));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pulse(input logic [2:0] m);
        @(posedge clk);
        done <= m;
        @(posedge clk);
        done <= 3'h0;
        repeat (2) @(posedge clk);
        #1;
    endtask : pulse

    function automatic int exp_div(input int s, input int c);
        if (s == 3) return 1;
        if (s == 1 && c > 3) return (c == 7) ? 32768 : 1 << (2 * c);
        return 1 << c;
    endfunction : exp_div

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    initial begin
        #360000;
        mismatches++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a += 4) begin
            apb(1'b0, 12'(a), 32'h0);
            check(rd, 32'h0);
            check(32'(er), 32'(a == 12));
        end
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
        check(32'(er), 32'h1);
        apb(1'b1, cod_pkg::OFS_CLOCK_OUTPUT_CONTROL, 32'hFFFF_FFFF);
        apb(1'b0, cod_pkg::OFS_CLOCK_OUTPUT_CONTROL, 32'h0);
        check(rd, 32'h7D);
        $display("test registers done");
        for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 8; c++) begin
                if ((s == 1 && c > 5) || (s == 3 && c > 0 && c < 7)) continue;
                apb(1'b1, cod_pkg::OFS_CLOCK_OUTPUT_CONTROL, 32'((c << 4) | (s << 2) | 1));
                per = 2 * HALF[s] * exp_div(s, c);
                repeat (2) @(posedge pin);
                #1;
                c0 = rises;
                #(per + per / 2);
                check(32'(rises - c0), 32'h1);
            end
        end
        // Longest low-speed codes: no edge where a shorter ratio would give one
        for (int c = 6; c < 8; c++) begin
            apb(1'b1, cod_pkg::OFS_CLOCK_OUTPUT_CONTROL, 32'((c << 4) | 5));
            repeat (2) @(posedge clk);
            #1;
            c0 = rises;
            #30000;
            check(32'(rises - c0), 32'h0);
        end
        $display("test ratios done");
        apb(1'b1, cod_pkg::OFS_CLOCK_OUTPUT_CONTROL, 32'h0);
        repeat (2) @(posedge clk);
        #1;
        c0 = rises;
        #2000;
        check(32'(rises - c0), 32'h0);
        check(32'(pin), 32'h0);
        apb(1'b1, cod_pkg::OFS_CLOCK_OUTPUT_CONTROL, 32'h0D);
        repeat (2) @(posedge pin);
        @(posedge clk);
        standby <= 1'b1;
        repeat (10) @(posedge clk);
        c0 = rises;
        #2000;
        check(32'(rises - c0), 32'h0);
        standby <= 1'b0;
        $display("test gating done");
        for (int b = 0; b < 3; b++) begin
            apb(1'b1, cod_pkg::OFS_CLOCKGEN_INTERRUPT_ENABLE, 32'(1 << b));
            pulse(3'(1 << b));
            check(32'(irq), 32'h1);
            apb(1'b1, cod_pkg::OFS_CLOCKGEN_INTERRUPT_FLAG, 32'h0);
            apb(1'b0, cod_pkg::OFS_CLOCKGEN_INTERRUPT_FLAG, 32'h0);
            check(rd, 32'(1 << b));
            apb(1'b1, cod_pkg::OFS_CLOCKGEN_INTERRUPT_FLAG, 32'(1 << b));
            apb(1'b0, cod_pkg::OFS_CLOCKGEN_INTERRUPT_FLAG, 32'h0);
            check(rd, 32'h0);
            check(32'(irq), 32'h0);
            apb(1'b1, cod_pkg::OFS_CLOCKGEN_INTERRUPT_ENABLE, 32'h0);
            pulse(3'(1 << b));
            check(32'(irq), 32'h0);
            apb(1'b0, cod_pkg::OFS_CLOCKGEN_INTERRUPT_FLAG, 32'h0);
            check(rd, 32'(1 << b));
            apb(1'b1, cod_pkg::OFS_CLOCKGEN_INTERRUPT_FLAG, 32'h7);
        end
        $display("test interrupts done");
        end_sim();
    end
endmodule : cod_clock_output_divider_tb
